//--- src/volt_mon_pkg.sv
/*
  Package for the supply voltage monitor fault-reaction block: register map,
  field positions, event indices, deglitch and timeout figures, carrier types.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package volt_mon_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned DEG_RAIL_NS     = 21000;   // Regulator and external rails
  localparam int unsigned DEG_INTERNAL_REGULATOR_RAIL_UV_NS  = 24000;
  localparam int unsigned DEG_FAST_OV_NS  = 10000;   // Battery, internal and I/O OV
  localparam int unsigned DEG_VBAT_UV_NS  = 90000;
  localparam int unsigned OVP_OFF_TIME_NS = 1000000; // Regulator OVP off-timeout
  localparam int unsigned DEG_RAIL_CYC    = (DEG_RAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG_INTERNAL_REGULATOR_RAIL_UV_CYC = (DEG_INTERNAL_REGULATOR_RAIL_UV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG_FAST_OV_CYC = (DEG_FAST_OV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG_VBAT_UV_CYC = (DEG_VBAT_UV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OVP_OFF_CYC     = (OVP_OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEG_W           = 14;
  localparam int unsigned OVP_W           = 20;

  // ----------------------------------------------------------------------
  // Comparator event indices
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_EV      = 18;
  localparam int unsigned EV_PRE_UV   = 0;
  localparam int unsigned EV_CORE_UV  = 1;
  localparam int unsigned EV_SU_UV    = 2;
  localparam int unsigned EV_INTERNAL_REGULATOR_RAIL_UV  = 3;
  localparam int unsigned EV_VBAT_UV  = 4;
  localparam int unsigned EV_EXT0_UV  = 5;  // Channel 1 is the next index
  localparam int unsigned EV_PRE_OV   = 7;
  localparam int unsigned EV_CORE_OV  = 8;
  localparam int unsigned EV_SU_OV    = 9;
  localparam int unsigned EV_INTERNAL_REGULATOR_RAIL_OV  = 10;
  localparam int unsigned EV_VBAT_OV  = 11;
  localparam int unsigned EV_VIO_OV   = 12;
  localparam int unsigned EV_EXT0_OV  = 13; // Channel 1 is the next index
  localparam int unsigned EV_PRE_OVP  = 15;
  localparam int unsigned EV_CORE_OVP = 16;
  localparam int unsigned EV_SU_OVP   = 17;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG    = 8'h00;
  localparam logic [7:0] REG_UV_FLAGS  = 8'h04;
  localparam logic [7:0] REG_OV_FLAGS  = 8'h08;
  localparam logic [7:0] REG_PRE_SAFE  = 8'h0C;
  localparam logic [7:0] REG_CORE_SAFE = 8'h10;
  localparam logic [7:0] REG_SU_SAFE   = 8'h14;
  localparam logic [7:0] REG_EXT_FLAGS = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h20;
  localparam logic [7:0] REG_STATUS    = 8'h24;
  localparam logic [7:0] REG_LEVELS    = 8'h28;

  // ----------------------------------------------------------------------
  // Configuration fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CFG_PRE_UV_RST   = 0;
  localparam int unsigned CFG_PRE_OV_RST   = 1;
  localparam int unsigned CFG_PRE_OVP_OFF  = 2;
  localparam int unsigned CFG_CORE_UV_RST  = 3;
  localparam int unsigned CFG_CORE_OV_RST  = 4;
  localparam int unsigned CFG_SU_UV_RST    = 5;
  localparam int unsigned CFG_SU_OV_RST    = 6;
  localparam int unsigned CFG_LOW_SUP_IRQ  = 7;
  localparam int unsigned CFG_EXT_UV_RST   = 8;   // Bits 9:8, one per channel
  localparam int unsigned CFG_EXT_UV_IRQ   = 10;  // Bits 11:10
  localparam int unsigned CFG_EXT_OV_RST   = 12;  // Bits 13:12
  localparam int unsigned CFG_EXT_OV_IRQ   = 14;  // Bits 15:14
  localparam int unsigned CFG_EN_RELEASE   = 16;  // Write-one action, reads zero
  localparam logic [15:0] CFG_RESET        = 16'h0000;
  localparam int unsigned FLAG_SAFE_OVP    = 3;
  localparam int unsigned FLAG_EXT_OV0     = 4;
  localparam int unsigned IRQ_UV           = 0;
  localparam int unsigned IRQ_OV           = 1;
  localparam int unsigned IRQ_SAFE         = 2;
  localparam int unsigned IRQ_EXT          = 3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_NONE  = 2'b00,
    REQ_SAFE  = 2'b01,
    REQ_RESET = 2'b10,
    REQ_OFF   = 2'b11
  } dev_req_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [NUM_EV-1:0]            sync1, sync2, sync3, stable, filt;
    logic [NUM_EV-1:0][DEG_W-1:0] cnt;
    logic [15:0]                  cfg;
    logic [7:0]                   uv_flags, ov_flags, ext_flags;
    logic [7:0]                   pre_safe, core_safe, su_safe;
    logic [3:0]                   irq_stat, irq_mask;
    logic                         ack;
    logic [31:0]                  dat;
    dev_req_t                     req;
    logic                         req_valid;
    logic                         rst_n, en, hiz, core_dis, su_dis;
    logic [OVP_W-1:0]             core_ovp_cnt, su_ovp_cnt;
    logic                         core_ovp_done, su_ovp_done;
  } state_t;

endpackage : volt_mon_pkg

//--- src/volt_mon_react.sv
/*
  Fault-reaction logic of the supply voltage monitor: deglitches comparator
  events, keeps sticky monitor flags, requests OFF, RESET or SAFE from the
  device state machine and drives the MCU reset and enable/interrupt pins.
  Assumes comparator outputs arrive asynchronously, the state machine pulses
  reset_release_i when it leaves RESET or OFF, and a classic Wishbone master.
*/
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - A pre-regulator undervoltage sets UV flag bit 0 and asks for RESET (reset and enable low) if its reset enable is set, else SAFE.
// - A core-regulator undervoltage sets UV flag bit 1 and asks for RESET if enabled, else only pulls the enable output low.
// - A step-up undervoltage sets UV flag bit 3 and asks for RESET if enabled, else changes nothing else.
// - A pre, core or step-up overvoltage sets OV flag bit 0, 1 or 3 and asks for RESET if enabled, else SAFE.
// - A pre-regulator overvoltage-protection event sets its safety bit 3 and asks for OFF if enabled, else SAFE.
// - An external-rail undervoltage sets its bit in external flags 1:0 and asks RESET if enabled, else SAFE if its interrupt enable is set.
// - An external-rail overvoltage sets its bit in external flags 5:4 and asks RESET if enabled, else SAFE if its interrupt enable is set.
// - An internal-rail undervoltage or overvoltage sets bit 4 of the matching flags and asks for OFF with both outputs low.
// - A battery overvoltage sets OV flag bit 6 and asks for OFF with both outputs low.
// - An I/O supply overvoltage sets OV flag bit 7, keeps the state and releases both pin drivers.
// - A battery undervoltage sets UV flag bit 6 and pulls the enable output low only when the low-supply interrupt enable is set.
// - A core or step-up overvoltage-protection event sets its safety bit 3, asks SAFE, disables the regulator and asks OFF if it persists for the off-timeout.
// - Each rail is deglitched, so an event shorter than its deglitch time has no effect at all.
// - A set flag stays set until software reads it while its fault is no longer present.
module volt_mon_react
  import volt_mon_pkg::*;
#(
  parameter int unsigned VBAT_UV_DEG_CYCLES = DEG_VBAT_UV_CYC,
  parameter int unsigned OVP_OFF_CYCLES     = OVP_OFF_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   irq_o,
  // Comparator events and state machine link
  input  wire logic [NUM_EV-1:0] cmp_event_i,
  input  wire logic              reset_release_i,
  output dev_req_t               state_req_o,
  output logic                   state_req_valid_o,
  output logic                   core_reg_disable_o,
  output logic                   step_up_disable_o,
  // Pins
  output logic                   mcu_reset_out_n_o,
  output logic                   mcu_reset_out_n_oe_o,
  output logic                   enable_drive_irq_out_o,
  output logic                   enable_drive_irq_out_oe_o
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Deglitch length of each comparator event
  function automatic logic [DEG_W-1:0] deg_len(input int unsigned idx);
    int unsigned c;
    case (idx)
      EV_INTERNAL_REGULATOR_RAIL_UV:                          c = DEG_INTERNAL_REGULATOR_RAIL_UV_CYC;
      EV_VBAT_UV:                          c = VBAT_UV_DEG_CYCLES;
      EV_INTERNAL_REGULATOR_RAIL_OV, EV_VBAT_OV, EV_VIO_OV:   c = DEG_FAST_OV_CYC;
      default:                             c = DEG_RAIL_CYC;
    endcase
    return c[DEG_W-1:0];
  endfunction : deg_len
  // More severe of two requests
  function automatic dev_req_t worst(input dev_req_t a, input dev_req_t b);
    return (b > a) ? b : a;
  endfunction : worst
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  state_t   s_r;
  state_t   s_nxt;
  wb_req_t  bus;
  logic [NUM_EV-1:0] rise;
  logic [7:0]        uv_set, ov_set, ext_set, uv_pres, ov_pres, ext_pres;
  logic [7:0]        pre_set, core_set, su_set;
  logic [31:0]       rd_data, wr_word;
  dev_req_t          req;
  logic              en_low;
  logic              commit;

  assign bus = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // Read data for the addressed register; unmapped addresses read zero
  always_comb begin
    case ({bus.adr[7:2], 2'b00})
      REG_CONFIG:    rd_data = {16'h0000, s_r.cfg};
      REG_UV_FLAGS:  rd_data = {24'h000000, s_r.uv_flags};
      REG_OV_FLAGS:  rd_data = {24'h000000, s_r.ov_flags};
      REG_PRE_SAFE:  rd_data = {24'h000000, s_r.pre_safe};
      REG_CORE_SAFE: rd_data = {24'h000000, s_r.core_safe};
      REG_SU_SAFE:   rd_data = {24'h000000, s_r.su_safe};
      REG_EXT_FLAGS: rd_data = {24'h000000, s_r.ext_flags};
      REG_IRQ_STAT:  rd_data = {28'h0000000, s_r.irq_stat};
      REG_IRQ_MASK:  rd_data = {28'h0000000, s_r.irq_mask};
      REG_STATUS:    rd_data = {25'h0000000, s_r.su_dis, s_r.core_dis, s_r.hiz, s_r.en, s_r.rst_n, s_r.req};
      REG_LEVELS:    rd_data = {14'h0000, s_r.filt};
      default:       rd_data = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    s_nxt   = s_r;
    commit  = bus.cyc & bus.stb & s_r.ack;
    wr_word = merge({16'h0000, s_r.cfg}, bus.dat, bus.sel);
    // Three-stage synchroniser, deglitch counter per event
    s_nxt.sync1 = cmp_event_i;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    for (int i = 0; i < NUM_EV; i++) begin
      if (s_r.sync2[i] == s_r.sync3[i]) begin
        s_nxt.stable[i] = s_r.sync3[i];
      end
      if (!s_r.stable[i]) begin
        s_nxt.cnt[i]  = '0;
        s_nxt.filt[i] = 1'b0;
      end else if (s_r.cnt[i] < deg_len(i)) begin
        s_nxt.cnt[i]  = s_r.cnt[i] + 1'b1;
      end else begin
        s_nxt.filt[i] = 1'b1;
      end
    end
    rise = s_nxt.filt & ~s_r.filt;
    // Flag set and fault-present vectors in register layout
    uv_set   = {1'b0, rise[EV_VBAT_UV], 1'b0, rise[EV_INTERNAL_REGULATOR_RAIL_UV], rise[EV_SU_UV], 1'b0,
                rise[EV_CORE_UV], rise[EV_PRE_UV]};
    ov_set   = {rise[EV_VIO_OV], rise[EV_VBAT_OV], 1'b0, rise[EV_INTERNAL_REGULATOR_RAIL_OV], rise[EV_SU_OV], 1'b0,
                rise[EV_CORE_OV], rise[EV_PRE_OV]};
    ext_set  = {2'b00, rise[EV_EXT0_OV+1], rise[EV_EXT0_OV], 2'b00,
                rise[EV_EXT0_UV+1], rise[EV_EXT0_UV]};
    uv_pres  = {1'b0, s_r.filt[EV_VBAT_UV], 1'b0, s_r.filt[EV_INTERNAL_REGULATOR_RAIL_UV], s_r.filt[EV_SU_UV], 1'b0,
                s_r.filt[EV_CORE_UV], s_r.filt[EV_PRE_UV]};
    ov_pres  = {s_r.filt[EV_VIO_OV], s_r.filt[EV_VBAT_OV], 1'b0, s_r.filt[EV_INTERNAL_REGULATOR_RAIL_OV],
                s_r.filt[EV_SU_OV], 1'b0, s_r.filt[EV_CORE_OV], s_r.filt[EV_PRE_OV]};
    ext_pres = {2'b00, s_r.filt[EV_EXT0_OV+1], s_r.filt[EV_EXT0_OV], 2'b00,
                s_r.filt[EV_EXT0_UV+1], s_r.filt[EV_EXT0_UV]};
    pre_set  = 8'(rise[EV_PRE_OVP])  << FLAG_SAFE_OVP;
    core_set = 8'(rise[EV_CORE_OVP]) << FLAG_SAFE_OVP;
    su_set   = 8'(rise[EV_SU_OVP])   << FLAG_SAFE_OVP;
    // Bus: take request, answer one cycle later, act at the acknowledged edge
    s_nxt.ack = bus.cyc & bus.stb & ~s_r.ack;
    if (bus.cyc & bus.stb & ~s_r.ack) begin
      s_nxt.dat = rd_data;
    end
    if (commit && bus.we) begin
      case ({bus.adr[7:2], 2'b00})
        REG_CONFIG: begin
          s_nxt.cfg = wr_word[15:0];
          if (wr_word[CFG_EN_RELEASE] && !(|s_r.filt)) begin
            s_nxt.en = 1'b1;
          end
        end
        REG_IRQ_MASK: s_nxt.irq_mask = wr_word[3:0];
        default: ;
      endcase
    end
    if (commit && !bus.we) begin
      case ({bus.adr[7:2], 2'b00})
        REG_UV_FLAGS:  s_nxt.uv_flags  = s_r.uv_flags & uv_pres;
        REG_OV_FLAGS:  s_nxt.ov_flags  = s_r.ov_flags & ov_pres;
        REG_EXT_FLAGS: s_nxt.ext_flags = s_r.ext_flags & ext_pres;
        REG_PRE_SAFE:  s_nxt.pre_safe  = s_r.pre_safe & (8'(s_r.filt[EV_PRE_OVP]) << FLAG_SAFE_OVP);
        REG_CORE_SAFE: s_nxt.core_safe = s_r.core_safe & (8'(s_r.filt[EV_CORE_OVP]) << FLAG_SAFE_OVP);
        REG_SU_SAFE:   s_nxt.su_safe   = s_r.su_safe & (8'(s_r.filt[EV_SU_OVP]) << FLAG_SAFE_OVP);
        REG_IRQ_STAT:  s_nxt.irq_stat  = 4'h0;
        default: ;
      endcase
    end
    // Sticky flags: a set in the clearing cycle wins
    s_nxt.uv_flags  = s_nxt.uv_flags | uv_set;
    s_nxt.ov_flags  = s_nxt.ov_flags | ov_set;
    s_nxt.ext_flags = s_nxt.ext_flags | ext_set;
    s_nxt.pre_safe  = s_nxt.pre_safe | pre_set;
    s_nxt.core_safe = s_nxt.core_safe | core_set;
    s_nxt.su_safe   = s_nxt.su_safe | su_set;
    s_nxt.irq_stat  = s_nxt.irq_stat | {|ext_set, |(pre_set | core_set | su_set), |ov_set, |uv_set};
    // State machine leaving RESET/OFF releases the reset pin and regulators; enable waits for a release write
    if (reset_release_i) begin
      s_nxt.rst_n         = 1'b1;
      s_nxt.core_dis      = 1'b0;
      s_nxt.su_dis        = 1'b0;
      s_nxt.core_ovp_done = 1'b0;
      s_nxt.su_ovp_done   = 1'b0;
    end
    // Reaction per event, merged by severity
    req    = REQ_NONE;
    en_low = 1'b0;
    if (rise[EV_PRE_UV]) begin
      req = worst(req, s_r.cfg[CFG_PRE_UV_RST] ? REQ_RESET : REQ_SAFE);
    end
    if (rise[EV_CORE_UV]) begin
      if (s_r.cfg[CFG_CORE_UV_RST]) begin
        req = worst(req, REQ_RESET);
      end else begin
        en_low = 1'b1;
      end
    end
    if (rise[EV_SU_UV] && s_r.cfg[CFG_SU_UV_RST]) begin
      req = worst(req, REQ_RESET);
    end
    if (rise[EV_PRE_OV]) begin
      req = worst(req, s_r.cfg[CFG_PRE_OV_RST] ? REQ_RESET : REQ_SAFE);
    end
    if (rise[EV_CORE_OV]) begin
      req = worst(req, s_r.cfg[CFG_CORE_OV_RST] ? REQ_RESET : REQ_SAFE);
    end
    if (rise[EV_SU_OV]) begin
      req = worst(req, s_r.cfg[CFG_SU_OV_RST] ? REQ_RESET : REQ_SAFE);
    end
    if (rise[EV_PRE_OVP]) begin
      req = worst(req, s_r.cfg[CFG_PRE_OVP_OFF] ? REQ_OFF : REQ_SAFE);
    end
    for (int c = 0; c < 2; c++) begin
      if (rise[EV_EXT0_UV+c]) begin
        if (s_r.cfg[CFG_EXT_UV_RST+c]) begin
          req = worst(req, REQ_RESET);
        end else if (s_r.cfg[CFG_EXT_UV_IRQ+c]) begin
          req = worst(req, REQ_SAFE);
        end
      end
      if (rise[EV_EXT0_OV+c]) begin
        if (s_r.cfg[CFG_EXT_OV_RST+c]) begin
          req = worst(req, REQ_RESET);
        end else if (s_r.cfg[CFG_EXT_OV_IRQ+c]) begin
          req = worst(req, REQ_SAFE);
        end
      end
    end
    if (rise[EV_INTERNAL_REGULATOR_RAIL_UV] || rise[EV_INTERNAL_REGULATOR_RAIL_OV] || rise[EV_VBAT_OV]) begin
      req = worst(req, REQ_OFF);
    end
    if (rise[EV_VBAT_UV] && s_r.cfg[CFG_LOW_SUP_IRQ]) begin
      en_low = 1'b1;
    end
    // Regulator overvoltage protection: disable, then off after timeout
    if (rise[EV_CORE_OVP]) begin
      req = worst(req, REQ_SAFE);
      s_nxt.core_dis = 1'b1;
    end
    if (rise[EV_SU_OVP]) begin
      req = worst(req, REQ_SAFE);
      s_nxt.su_dis = 1'b1;
    end
    if (s_r.core_dis && s_r.filt[EV_CORE_OVP] && !s_r.core_ovp_done) begin
      s_nxt.core_ovp_cnt = s_r.core_ovp_cnt + 1'b1;
      if (s_r.core_ovp_cnt == OVP_W'(OVP_OFF_CYCLES - 1)) begin
        req = worst(req, REQ_OFF);
        s_nxt.core_ovp_done = 1'b1;
      end
    end else begin
      s_nxt.core_ovp_cnt = '0;
    end
    if (s_r.su_dis && s_r.filt[EV_SU_OVP] && !s_r.su_ovp_done) begin
      s_nxt.su_ovp_cnt = s_r.su_ovp_cnt + 1'b1;
      if (s_r.su_ovp_cnt == OVP_W'(OVP_OFF_CYCLES - 1)) begin
        req = worst(req, REQ_OFF);
        s_nxt.su_ovp_done = 1'b1;
      end
    end else begin
      s_nxt.su_ovp_cnt = '0;
    end
    // Apply the single most severe request to the pins
    s_nxt.req       = req;
    s_nxt.req_valid = (req != REQ_NONE);
    case (req)
      REQ_OFF, REQ_RESET: begin
        s_nxt.rst_n = 1'b0;
        s_nxt.en    = 1'b0;
      end
      REQ_SAFE: begin
        s_nxt.rst_n = 1'b1;
        s_nxt.en    = 1'b0;
      end
      default: ;
    endcase
    if (en_low) begin
      s_nxt.en = 1'b0;
    end
    // I/O supply overvoltage floats both pins while present
    s_nxt.hiz = s_nxt.filt[EV_VIO_OV];
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.cfg      <= CFG_RESET;
      s_r.req      <= REQ_NONE;
      s_r.rst_n    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign wb_dat_o                  = s_r.dat;
  assign wb_ack_o                  = s_r.ack;
  assign irq_o                     = |(s_r.irq_stat & s_r.irq_mask);
  assign state_req_o               = s_r.req;
  assign state_req_valid_o         = s_r.req_valid;
  assign core_reg_disable_o        = s_r.core_dis;
  assign step_up_disable_o         = s_r.su_dis;
  assign mcu_reset_out_n_o         = s_r.rst_n;
  assign mcu_reset_out_n_oe_o      = ~s_r.hiz;
  assign enable_drive_irq_out_o    = s_r.en;
  assign enable_drive_irq_out_oe_o = ~s_r.hiz;

endmodule : volt_mon_react

`default_nettype wire

//--- sim/volt_mon_react_assertions.sv
/* Port checker for the fault-reaction block.
   Assumes it is bound to volt_mon_react and that the block has one clock. */
`timescale 1ns/1ps
`default_nettype none
module volt_mon_react_assertions
  import volt_mon_pkg::*;
(
  // Watched ports
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic [NUM_EV-1:0] cmp_event_i,
  input wire dev_req_t          state_req_o,
  input wire logic              state_req_valid_o,
  input wire logic              mcu_reset_out_n_o,
  input wire logic              mcu_reset_out_n_oe_o,
  input wire logic              enable_drive_irq_out_o,
  input wire logic              enable_drive_irq_out_oe_o
);
  logic [15:0] run_r;

  // Counts cycles with any comparator event present
  always_ff @(posedge clk_i) begin
    if (rst_i || cmp_event_i == '0) run_r <= 16'h0000;
    else if (run_r != 16'hFFFF) run_r <= run_r + 16'h0001;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wb_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence req_is(dev_req_t r); state_req_valid_o && state_req_o == r; endsequence

  ack_timing_a: assert property (wb_taken |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  reset_req_a: assert property (req_is(REQ_RESET) |-> !mcu_reset_out_n_o && !enable_drive_irq_out_o)
    else $error("reset pins wrong");
  off_req_a: assert property (req_is(REQ_OFF) |-> !mcu_reset_out_n_o && !enable_drive_irq_out_o)
    else $error("off pins wrong");
  safe_req_a: assert property (req_is(REQ_SAFE) |-> mcu_reset_out_n_o && !enable_drive_irq_out_o)
    else $error("safe pins wrong");
  pin_hiz_a: assert property ($fell(mcu_reset_out_n_oe_o) |->
    !enable_drive_irq_out_oe_o && $past(cmp_event_i[EV_VIO_OV], 8)) else $error("drivers split");
  reset_fall_a: assert property ($fell(mcu_reset_out_n_o) |-> state_req_valid_o && state_req_o[1])
    else $error("reset pin fell alone");
  deglitch_a: assert property (state_req_valid_o && state_req_o != REQ_NONE |-> run_r >= 16'h03E8)
    else $error("request before deglitch");
endmodule : volt_mon_react_assertions

bind volt_mon_react volt_mon_react_assertions i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .cmp_event_i(cmp_event_i), .state_req_o(state_req_o), .state_req_valid_o(state_req_valid_o),
  .mcu_reset_out_n_o(mcu_reset_out_n_o), .mcu_reset_out_n_oe_o(mcu_reset_out_n_oe_o),
  .enable_drive_irq_out_o(enable_drive_irq_out_o), .enable_drive_irq_out_oe_o(enable_drive_irq_out_oe_o));
`default_nettype wire

//--- sim/mcu_pin_model.sv
/* MCU side of the reset and enable/interrupt pins.
   Assumes a pull-up on the reset line and a pull-down on the enable line. */
`timescale 1ns/1ps
`default_nettype none
module mcu_pin_model (
  // Device pin drivers
  input  wire logic rst_n_val_i,
  input  wire logic rst_n_oe_i,
  input  wire logic en_val_i,
  input  wire logic en_oe_i,
  // Levels the MCU sees
  output logic      rst_n_seen_o,
  output logic      en_seen_o
);
  // Released lines go to their pull level
  assign rst_n_seen_o = rst_n_oe_i ? rst_n_val_i : 1'b1;
  assign en_seen_o    = en_oe_i ? en_val_i : 1'b0;
endmodule : mcu_pin_model
`default_nettype wire

//--- sim/tb_top.sv
/* Self-checking bench for the fault-reaction block.
   Assumes the package, pin model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import volt_mon_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, rel = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [NUM_EV-1:0] ev = '0;
  logic ack, irq, vld, rst_n, rst_n_oe, en, en_oe, rst_n_seen, en_seen, cdis, sdis;
  dev_req_t req;
  int errors = 0, comparisons = 0;
  always #5 clk_i = ~clk_i;
  volt_mon_react #(.VBAT_UV_DEG_CYCLES(20), .OVP_OFF_CYCLES(50)) i_volt_mon_react (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .cmp_event_i(ev),
    .reset_release_i(rel), .state_req_o(req), .state_req_valid_o(vld), .core_reg_disable_o(cdis),
    .step_up_disable_o(sdis), .mcu_reset_out_n_o(rst_n), .mcu_reset_out_n_oe_o(rst_n_oe),
    .enable_drive_irq_out_o(en), .enable_drive_irq_out_oe_o(en_oe));
  mcu_pin_model i_mcu_pin_model (.rst_n_val_i(rst_n), .rst_n_oe_i(rst_n_oe), .en_val_i(en), .en_oe_i(en_oe),
    .rst_n_seen_o(rst_n_seen), .en_seen_o(en_seen));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : wb
  // One fault: reaction, sticky flag, read-clear, interrupt, release
  task automatic fault(input logic [NUM_EV-1:0] e, input logic [15:0] c, input logic [7:0] a, input int b,
                       input dev_req_t r, input logic xr, input logic xe);
    wb(1'b1, REG_CONFIG, {16'h0000, c});
    ev <= e;
    for (int i = 0; i < 3000 && vld !== 1'b1 && !(r == REQ_NONE && i == 2200); i++) @(posedge clk_i);
    chk("reaction", {r != REQ_NONE, r, xr, xe}, {vld, req, rst_n_seen, en_seen});
    chk("disable", {e[EV_SU_OVP], e[EV_CORE_OVP]}, {sdis, cdis});
    wb(1'b0, a, 32'h0);
    chk("flag set", 32'h1 << b, q);
    chk("irq", 32'h1, {31'h0, irq});
    ev <= '0;
    repeat (2200) @(posedge clk_i);
    wb(1'b0, a, 32'h0);
    chk("flag held", 32'h1 << b, q);
    wb(1'b0, a, 32'h0);
    chk("flag cleared", 32'h0, q);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rel <= 1'b1;
    @(posedge clk_i);
    rel <= 1'b0;
    wb(1'b1, REG_CONFIG, {15'h0000, 1'b1, c});
  endtask : fault
  task automatic uv_faults;
    fault(18'h00001, 16'h0001, REG_UV_FLAGS, 0, REQ_RESET, 1'b0, 1'b0);
    fault(18'h00001, 16'h0000, REG_UV_FLAGS, 0, REQ_SAFE, 1'b1, 1'b0);
    fault(18'h00002, 16'h0000, REG_UV_FLAGS, 1, REQ_NONE, 1'b1, 1'b0);
    fault(18'h00004, 16'h0000, REG_UV_FLAGS, 3, REQ_NONE, 1'b1, 1'b1);
    fault(18'h00008, 16'h0000, REG_UV_FLAGS, 4, REQ_OFF, 1'b0, 1'b0);
    fault(18'h00010, 16'h0080, REG_UV_FLAGS, 6, REQ_NONE, 1'b1, 1'b0);
  endtask : uv_faults
  task automatic ov_faults;
    fault(18'h00100, 16'h0010, REG_OV_FLAGS, 1, REQ_RESET, 1'b0, 1'b0);
    fault(18'h00200, 16'h0000, REG_OV_FLAGS, 3, REQ_SAFE, 1'b1, 1'b0);
    fault(18'h00800, 16'h0000, REG_OV_FLAGS, 6, REQ_OFF, 1'b0, 1'b0);
    fault(18'h01000, 16'h0000, REG_OV_FLAGS, 7, REQ_NONE, 1'b1, 1'b0);
  endtask : ov_faults
  task automatic other_faults;
    fault(18'h08000, 16'h0000, REG_PRE_SAFE, 3, REQ_SAFE, 1'b1, 1'b0);
    fault(18'h10000, 16'h0000, REG_CORE_SAFE, 3, REQ_SAFE, 1'b1, 1'b0);
    fault(18'h00020, 16'h0400, REG_EXT_FLAGS, 0, REQ_SAFE, 1'b1, 1'b0);
    fault(18'h04000, 16'h2000, REG_EXT_FLAGS, 5, REQ_RESET, 1'b0, 1'b0);
    fault(18'h08001, 16'h0005, REG_UV_FLAGS, 0, REQ_OFF, 1'b0, 1'b0);
  endtask : other_faults
  // Held step-up protection event: SAFE and disable first, OFF after the off-timeout
  task automatic ovp_off;
    ev <= 18'h20000;
    for (int i = 0; i < 3000 && !(vld === 1'b1 && req == REQ_OFF); i++) @(posedge clk_i);
    chk("ovp off", {1'b1, REQ_OFF, 2'b01}, {vld, req, rst_n_seen, sdis});
  endtask : ovp_off
  // Short pulse must leave no trace
  task automatic glitch;
    ev <= 18'h00001;
    repeat (500) @(posedge clk_i);
    ev <= '0;
    repeat (2200) @(posedge clk_i);
    wb(1'b0, REG_UV_FLAGS, 32'h0);
    chk("glitch flag", 32'h0, q);
  endtask : glitch
  task automatic close_out;
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, REG_IRQ_MASK, 32'h0000000F);
    wb(1'b1, REG_CONFIG, 32'h00010000);
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, q);
    uv_faults;
    ov_faults;
    other_faults;
    ovp_off;
    glitch;
    close_out;
  end
  // Watchdog
  initial begin
    repeat (95000) @(posedge clk_i);
    errors++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
